// [rtl/var_relay_defs.svh]
`ifndef VAR_RELAY_DEFS_SVH
`define VAR_RELAY_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets, field positions and reset values
// ----------------------------------------------------------------------
`define VAR_OFF_STATUS    4'h0
`define VAR_OFF_MASK      4'h4
`define VAR_OFF_CTRL      4'h8
`define VAR_OFF_STATE     4'hc
`define VAR_EVT_W         4
`define VAR_EVT_SET       0
`define VAR_EVT_CLR       1
`define VAR_EVT_OK_LOST   2
`define VAR_EVT_EMERG     3
`define VAR_CTRL_PRESS    0
`define VAR_MASK_RST      4'h0
`define VAR_RESP_OKAY     2'h0
`define VAR_RESP_SLVERR   2'h2

// ----------------------------------------------------------------------
// Switch bank layout and timing
// ----------------------------------------------------------------------
`define VAR_SW_CLOSE_MODE 8
`define VAR_SW_AUTO_CLEAR 9
`define VAR_CFG_HTR_LO    4'h2
`define VAR_CFG_HTR_HI    4'h4
`define VAR_CLK_MHZ       125
`define VAR_DEBOUNCE_US   10
`define VAR_DEBOUNCE_CYC  (`VAR_DEBOUNCE_US * `VAR_CLK_MHZ)

`endif

// [rtl/var_relay_pkg.sv]
package var_relay_pkg;

    // ------------------------------------------------------------------
    // Conditions that may be routed to an indication relay
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        VAR_SRC_ALARM, VAR_SRC_FAULT, VAR_SRC_OPEN, VAR_SRC_CLOSE,
        VAR_SRC_WIND, VAR_SRC_OK, VAR_SRC_FIRE
    } var_src_t;

    // Internal status flags from logic on the same clock.
    typedef struct packed {
        logic smoke_exhaust_alarm;
        logic fault;
        logic wind_rain_detector;
        logic supply_ok;
        logic wire_break_m1;
        logic wire_break_m2;
        logic emergency_power;
    } var_flags_t;

    // Vent drive and relay outputs.
    typedef struct packed {
        logic       vent_open;
        logic       vent_close;
        logic       energy_save;
        logic [1:0] indication_relays;
    } var_drive_t;

endpackage

// [rtl/var_relay_top.sv]
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "var_relay_defs.svh"

// Behaviour
// - Hold-to-run ventilation configurations disable the close-on-fire-alarm latch.
// - A latched close command keeps vents closed, ignoring the ventilation switch.
// - Close-on-fire-alarm triggering raises neither alarm nor fault indication.
// - No energy saving in emergency power while the close command is latched.
// - Automatic clearing cancels the latch when the contact returns; switch control resumes.
// - Cancelling the fire alarm in emergency power enters energy saving mode.
// - Switch 10 ON enables automatic fire-alarm clearing, OFF disables it.
// - Two relay outputs, each routed by the four-bit value of switches 5 to 8.
// - Fixed source pairs per setting; all OFF alarm/fault, all ON alarm/fire.
// - OK is true only with healthy supply and no motor line wire break.
// - OK drops whenever either motor line reports a wire break.
// - A fault relay is inverted: contact open on failure, closed otherwise.
// - In emergency power both relays rest de-energised.
// - The latched close command is selectable as a relay source.
// - Switch 9 ON makes fire alarm close vents; OFF makes it open them.
// - Two reset switch presses clear the latch if no fire alarm remains.
module var_relay_top #(
    parameter int DEBOUNCE_CYC = `VAR_DEBOUNCE_CYC
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic                    clk_en,
    input  wire logic [3:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [3:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic                    fire_alarm_input,
    input  wire logic [9:0]              config_switch_bank,
    input  wire logic                    reset_switch,
    input  wire logic                    vent_switch_open,
    input  wire logic                    vent_switch_close,
    input  wire var_relay_pkg::var_flags_t flags,
    output var_relay_pkg::var_drive_t    drive,
    output logic                         irq
);

    localparam int PW = 14;

    initial begin
        if (DEBOUNCE_CYC < 2 || DEBOUNCE_CYC > 4095) begin
            $error("DEBOUNCE_CYC out of range");
        end
    end

    // ------------------------------------------------------------------
    // Input synchroniser and debounce
    // ------------------------------------------------------------------
    logic [PW-1:0] pins;
    logic [PW-1:0] sync1_q;
    logic [PW-1:0] sync2_q;
    logic [PW-1:0] db_q;
    logic [11:0]   db_cnt_q;

    assign pins = {reset_switch, vent_switch_close, vent_switch_open,
                   fire_alarm_input, config_switch_bank};

    // Two flops per pin; only the second is read by logic.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (clk_en) begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    // The stable copy follows once the inputs have differed from it for DEBOUNCE_CYC cycles in a row.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            db_q     <= '0;
            db_cnt_q <= '0;
        end else if (clk_en) begin
            if (sync2_q == db_q) begin
                db_cnt_q <= '0;
            end else if (db_cnt_q == 12'(DEBOUNCE_CYC - 1)) begin
                db_q     <= sync2_q;
                db_cnt_q <= '0;
            end else begin
                db_cnt_q <= db_cnt_q + 12'h001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Decoded configuration
    // ------------------------------------------------------------------
    logic [3:0] vent_cfg;
    logic [3:0] relay_sel;
    logic       close_mode;
    logic       auto_clr;
    logic       htr;
    logic       fire_db;
    logic       rst_db;
    logic       vo_db;
    logic       vc_db;
    logic       fire_open;
    logic       ok;

    assign vent_cfg   = db_q[3:0];
    assign relay_sel  = db_q[7:4];
    assign close_mode = db_q[`VAR_SW_CLOSE_MODE];
    assign auto_clr   = db_q[`VAR_SW_AUTO_CLEAR];
    assign htr        = vent_cfg >= `VAR_CFG_HTR_LO && vent_cfg <= `VAR_CFG_HTR_HI;
    assign fire_db    = db_q[10];
    assign vo_db      = db_q[11];
    assign vc_db      = db_q[12];
    assign rst_db     = db_q[13];
    assign fire_open  = fire_db && !close_mode;
    assign ok = flags.supply_ok && !flags.wire_break_m1 && !flags.wire_break_m2;

    // ------------------------------------------------------------------
    // Close-on-fire-alarm latch and reset switch presses
    // ------------------------------------------------------------------
    logic       fa_latch_q;
    logic       rst_prev_q;
    logic       press_cnt_q;
    logic       soft_press_q;
    logic       press;
    logic       fa_set;
    logic       fa_clr;

    assign press  = (rst_db && !rst_prev_q) || soft_press_q;
    assign fa_set = close_mode && !htr && fire_db;
    assign fa_clr = htr || (auto_clr && !fire_db)
                 || (press && press_cnt_q && !fire_db);

    // Set wins over clear; clearing restores the ventilation switch.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fa_latch_q <= 1'b0;
        end else if (clk_en) begin
            if (fa_set) begin
                fa_latch_q <= 1'b1;
            end else if (fa_clr) begin
                fa_latch_q <= 1'b0;
            end
        end
    end

    // The first press only arms; the second one clears.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_prev_q  <= 1'b0;
            press_cnt_q <= 1'b0;
        end else if (clk_en) begin
            rst_prev_q <= rst_db;
            if (!fa_latch_q) begin
                press_cnt_q <= 1'b0;
            end else if (press) begin
                press_cnt_q <= !press_cnt_q;
            end
        end
    end

    // ------------------------------------------------------------------
    // Vent drive, energy saving and relay routing
    // ------------------------------------------------------------------
    function automatic var_relay_pkg::var_src_t pick(input logic [3:0] sel, input logic second);
        var_relay_pkg::var_src_t a;
        var_relay_pkg::var_src_t b;
        a = var_relay_pkg::VAR_SRC_ALARM;
        b = var_relay_pkg::VAR_SRC_FAULT;
        unique case (sel)
            4'h0: begin a = var_relay_pkg::VAR_SRC_ALARM; b = var_relay_pkg::VAR_SRC_FAULT; end
            4'h1: begin a = var_relay_pkg::VAR_SRC_ALARM; b = var_relay_pkg::VAR_SRC_OPEN;  end
            4'h2: begin a = var_relay_pkg::VAR_SRC_ALARM; b = var_relay_pkg::VAR_SRC_CLOSE; end
            4'h3: begin a = var_relay_pkg::VAR_SRC_ALARM; b = var_relay_pkg::VAR_SRC_WIND;  end
            4'h4: begin a = var_relay_pkg::VAR_SRC_ALARM; b = var_relay_pkg::VAR_SRC_OK;    end
            4'h5: begin a = var_relay_pkg::VAR_SRC_FAULT; b = var_relay_pkg::VAR_SRC_OPEN;  end
            4'h6: begin a = var_relay_pkg::VAR_SRC_FAULT; b = var_relay_pkg::VAR_SRC_CLOSE; end
            4'h7: begin a = var_relay_pkg::VAR_SRC_FAULT; b = var_relay_pkg::VAR_SRC_WIND;  end
            4'h8: begin a = var_relay_pkg::VAR_SRC_FAULT; b = var_relay_pkg::VAR_SRC_OK;    end
            4'h9: begin a = var_relay_pkg::VAR_SRC_OPEN;  b = var_relay_pkg::VAR_SRC_CLOSE; end
            4'ha: begin a = var_relay_pkg::VAR_SRC_OPEN;  b = var_relay_pkg::VAR_SRC_WIND;  end
            4'hb: begin a = var_relay_pkg::VAR_SRC_OPEN;  b = var_relay_pkg::VAR_SRC_OK;    end
            4'hc: begin a = var_relay_pkg::VAR_SRC_CLOSE; b = var_relay_pkg::VAR_SRC_WIND;  end
            4'hd: begin a = var_relay_pkg::VAR_SRC_CLOSE; b = var_relay_pkg::VAR_SRC_OK;    end
            4'he: begin a = var_relay_pkg::VAR_SRC_WIND;  b = var_relay_pkg::VAR_SRC_OK;    end
            4'hf: begin a = var_relay_pkg::VAR_SRC_ALARM; b = var_relay_pkg::VAR_SRC_FIRE;  end
        endcase
        return second ? b : a;
    endfunction

    logic [1:0] relay_d;

    // Fault drives its relay inverted; fire reports the latch or an open-mode alarm.
    always_comb begin
        relay_d = 2'h0;
        for (int i = 0; i < 2; i++) begin
            unique case (pick(relay_sel, i[0]))
                var_relay_pkg::VAR_SRC_ALARM: relay_d[i] = flags.smoke_exhaust_alarm;
                var_relay_pkg::VAR_SRC_FAULT: relay_d[i] = !flags.fault;
                var_relay_pkg::VAR_SRC_OPEN:  relay_d[i] = drive.vent_open;
                var_relay_pkg::VAR_SRC_CLOSE: relay_d[i] = drive.vent_close;
                var_relay_pkg::VAR_SRC_WIND:  relay_d[i] = flags.wind_rain_detector;
                var_relay_pkg::VAR_SRC_OK:    relay_d[i] = ok;
                var_relay_pkg::VAR_SRC_FIRE:  relay_d[i] = fa_latch_q || fire_open;
            endcase
        end
        if (flags.emergency_power) begin
            relay_d = 2'h0;
        end
    end

    // Smoke alarm first, then fire priority, latch, weather, then the switch.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive <= '0;
        end else if (clk_en) begin
            drive.indication_relays <= relay_d;
            drive.energy_save <= flags.emergency_power && !fa_latch_q;
            if (flags.smoke_exhaust_alarm || fire_open) begin
                drive.vent_open  <= 1'b1;
                drive.vent_close <= 1'b0;
            end else if (fa_latch_q || flags.wind_rain_detector) begin
                drive.vent_open  <= 1'b0;
                drive.vent_close <= 1'b1;
            end else begin
                drive.vent_open  <= vo_db && !vc_db;
                drive.vent_close <= vc_db && !vo_db;
            end
        end
    end

    // ------------------------------------------------------------------
    // Event status, mask and interrupt
    // ------------------------------------------------------------------
    logic [`VAR_EVT_W-1:0] status_q;
    logic [`VAR_EVT_W-1:0] mask_q;
    logic [`VAR_EVT_W-1:0] evt;
    logic [`VAR_EVT_W-1:0] w1c;
    logic                  ok_prev_q;
    logic                  emerg_prev_q;
    logic                  latch_prev_q;

    assign evt = {flags.emergency_power && !emerg_prev_q, !ok && ok_prev_q,
                  !fa_latch_q && latch_prev_q, fa_latch_q && !latch_prev_q};
    assign irq = |(status_q & mask_q);

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic        aw_hold_q;
    logic        w_hold_q;
    logic [3:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic        wstrb0_q;
    logic        do_write;

    assign s_axi_awready = clk_en && !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = clk_en && !w_hold_q && !s_axi_bvalid;
    assign s_axi_arready = clk_en && !s_axi_rvalid;
    assign do_write = clk_en && aw_hold_q && w_hold_q && !s_axi_bvalid;
    assign w1c = (do_write && awaddr_q == `VAR_OFF_STATUS && wstrb0_q)
               ? wdata_q[`VAR_EVT_W-1:0] : '0;

    // Address and data are held until both are present.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb0_q  <= 1'b0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // Register writes, write response and event capture; events win over clears.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q     <= '0;
            mask_q       <= `VAR_MASK_RST;
            soft_press_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `VAR_RESP_OKAY;
            ok_prev_q    <= 1'b0;
            emerg_prev_q <= 1'b0;
            latch_prev_q <= 1'b0;
        end else if (clk_en) begin
            ok_prev_q    <= ok;
            emerg_prev_q <= flags.emergency_power;
            latch_prev_q <= fa_latch_q;
            status_q     <= (status_q & ~w1c) | evt;
            soft_press_q <= do_write && awaddr_q == `VAR_OFF_CTRL && wstrb0_q
                         && wdata_q[`VAR_CTRL_PRESS];
            if (do_write && awaddr_q == `VAR_OFF_MASK && wstrb0_q) begin
                mask_q <= wdata_q[`VAR_EVT_W-1:0];
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q == `VAR_OFF_STATE) ? `VAR_RESP_SLVERR
                              : `VAR_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read data answers one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= `VAR_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `VAR_RESP_OKAY;
                unique case (s_axi_araddr)
                    `VAR_OFF_STATUS: s_axi_rdata <= 32'(status_q);
                    `VAR_OFF_MASK:   s_axi_rdata <= 32'(mask_q);
                    `VAR_OFF_CTRL:   s_axi_rdata <= 32'h0;
                    `VAR_OFF_STATE:  s_axi_rdata <= {16'h0, db_q[9:0], fa_latch_q, drive};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `VAR_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_second_press;
        clk_en && fa_latch_q && press && press_cnt_q && !fire_db && !fa_set;
    endsequence
    sequence s_db_update;
        clk_en && sync2_q != db_q && db_cnt_q == 12'(DEBOUNCE_CYC - 1);
    endsequence

    property p_htr_block;
        (clk_en && htr) |=> !fa_latch_q;
    endproperty
    a_htr_block: assert property (p_htr_block) else $error("latch set in hold-to-run");
    property p_latch_close;
        (clk_en && fa_latch_q && !flags.smoke_exhaust_alarm && !fire_open)
            |=> (drive.vent_close && !drive.vent_open);
    endproperty
    a_latch_close: assert property (p_latch_close) else $error("latch not closing");
    property p_no_save;
        (clk_en && flags.emergency_power && fa_latch_q) |=> !drive.energy_save;
    endproperty
    a_no_save: assert property (p_no_save) else $error("energy save while latched");
    property p_auto_clear;
        (clk_en && auto_clr && !fire_db) |=> !fa_latch_q;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("auto clear failed");
    property p_save_on;
        (clk_en && flags.emergency_power && !fa_latch_q) |=> drive.energy_save;
    endproperty
    a_save_on: assert property (p_save_on) else $error("energy save missing");
    property p_emerg_relay;
        (clk_en && flags.emergency_power) |=> drive.indication_relays == 2'h0;
    endproperty
    a_emerg_relay: assert property (p_emerg_relay) else $error("relay energised");
    property p_fault_inv;
        (clk_en && relay_sel == 4'h0 && !flags.emergency_power)
            |=> drive.indication_relays[1] == !$past(flags.fault);
    endproperty
    a_fault_inv: assert property (p_fault_inv) else $error("fault relay polarity");
    property p_ok_drop;
        (clk_en && relay_sel == 4'he && (flags.wire_break_m1 || flags.wire_break_m2))
            |=> !drive.indication_relays[1];
    endproperty
    a_ok_drop: assert property (p_ok_drop) else $error("OK held on wire break");
    property p_fire_set;
        (clk_en && close_mode && !htr && fire_db) |=> fa_latch_q ##1 !drive.energy_save;
    endproperty
    a_fire_set: assert property (p_fire_set) else $error("fire alarm not latched");
    property p_two_press;
        s_second_press |=> !fa_latch_q;
    endproperty
    a_two_press: assert property (p_two_press) else $error("second press ignored");
    property p_debounce;
        s_db_update |=> db_q == $past(sync2_q);
    endproperty
    a_debounce: assert property (p_debounce) else $error("debounce update lost");

endmodule // var_relay_top

// [testbench/var_fire_panel.sv]
`timescale 1ns/1ps
// Fire-alarm panel model: its contact follows the alarm state after LAG edges.
module var_fire_panel #(
    parameter int LAG = 2
) (
    input  wire logic aclk,
    input  wire logic alarm_cmd,
    output logic      fire_alarm_input
);
    logic [LAG-1:0] lag_q = '0;
    // Delay line, so the contact changes as late as a real panel may.
    always_ff @(posedge aclk) begin
        lag_q <= {lag_q[LAG-2:0], alarm_cmd};
    end
    assign fire_alarm_input = lag_q[LAG-1];
endmodule // var_fire_panel

// [testbench/var_relay_top_tb.sv]
`timescale 1ns/1ps
`include "var_relay_defs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module var_relay_top_tb;
    // Sources per select: high nibble contact 1, low nibble contact 2.
    localparam logic [127:0] MAP = 128'h06453534252423151413120504030201;
    logic        aclk = 1'h0, aresetn = 1'h0, alarm_cmd = 1'h0, reset_switch = 1'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h1;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h1, vent_switch_open = 1'h0;
    logic        vent_switch_close = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
    logic [9:0]  config_switch_bank = 10'h0;
    logic [6:0]  v;
    logic [1:0]  s_axi_bresp, s_axi_rresp, e;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        irq, fire_alarm_input;
    int          fails = 0, compares = 0;
    var_relay_pkg::var_flags_t flags = 7'h00;
    var_relay_pkg::var_drive_t drive;

    // Clock of 8 ns.
    always #4 aclk = ~aclk;

    var_fire_panel i_panel (.aclk, .alarm_cmd, .fire_alarm_input);
    var_relay_top #(.DEBOUNCE_CYC(2)) i_dut (
        .aclk, .aresetn, .clk_en(1'h1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fire_alarm_input,
        .config_switch_bank, .reset_switch, .vent_switch_open, .vent_switch_close,
        .flags, .drive, .irq);

    // Write one word and compare the response code.
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        `CHK("bresp", er, s_axi_bresp)
    endtask

    // Read one word into rd_data and compare the response code.
    task automatic rd(input logic [3:0] a, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rd_data = s_axi_rdata;
        `CHK("rresp", er, s_axi_rresp)
    endtask

    // Apply alarm, switches, flags and vent switch, then wait out the debounce.
    task automatic put(input logic al, input logic [9:0] s, input logic [6:0] f, input logic o);
        alarm_cmd <= al;
        config_switch_bank <= s;
        flags <= f;
        vent_switch_open <= o;
        repeat (14) @(posedge aclk);
    endtask

    task automatic report_and_stop;
        $display("Mismatches %0d of %0d comparisons", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        report_and_stop();
    end

    // Main sequence.
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(`VAR_OFF_MASK, `VAR_RESP_OKAY);
        `CHK("mask", 32'h0, rd_data)
        rd(4'h2, `VAR_RESP_SLVERR);
        wr(`VAR_OFF_STATE, 32'h0, `VAR_RESP_SLVERR);
        for (int s = 0; s < 16; s++) begin
            for (int c = 0; c < 2; c++) begin
                put(1'h0, {2'h0, s[3:0], 4'h0}, c ? 7'h3c : 7'h48, 1'h0);
                v = c ? 7'h18 : 7'h27;
                e = {v[MAP[s*8 +: 4]], v[MAP[s*8+4 +: 4]]};
                `CHK("relays", e, drive.indication_relays)
                `CHK("vents", c ? 2'h1 : 2'h2, {drive.vent_open, drive.vent_close})
            end
        end
        put(1'h1, 10'h102, 7'h08, 1'h0);
        `CHK("hold_to_run", 5'h02, drive)
        put(1'h0, 10'h102, 7'h08, 1'h0);
        put(1'h0, 10'h1f0, 7'h08, 1'h0);
        wr(`VAR_OFF_STATUS, 32'hf, `VAR_RESP_OKAY);
        put(1'h1, 10'h1f0, 7'h08, 1'h1);
        `CHK("latched", 5'h0a, drive)
        rd(`VAR_OFF_STATUS, `VAR_RESP_OKAY);
        `CHK("status", 32'h1, rd_data)
        `CHK("irq_masked", 1'h0, irq)
        wr(`VAR_OFF_MASK, 32'h1, `VAR_RESP_OKAY);
        `CHK("irq", 1'h1, irq)
        wr(`VAR_OFF_STATUS, 32'h1, `VAR_RESP_OKAY);
        `CHK("irq_clear", 1'h0, irq)
        put(1'h1, 10'h1f0, 7'h09, 1'h0);
        `CHK("emergency", 5'h08, drive)
        put(1'h0, 10'h1f0, 7'h09, 1'h0);
        reset_switch <= 1'h1;
        repeat (8) @(posedge aclk);
        reset_switch <= 1'h0;
        repeat (8) @(posedge aclk);
        `CHK("one_press", 5'h08, drive)
        wr(`VAR_OFF_CTRL, 32'h1, `VAR_RESP_OKAY);
        repeat (2) @(posedge aclk);
        `CHK("cleared", 5'h04, drive)
        rd(`VAR_OFF_STATUS, `VAR_RESP_OKAY);
        `CHK("status_evt", 32'ha, rd_data)
        put(1'h1, 10'h3f0, 7'h08, 1'h1);
        `CHK("auto_latch", 5'h0a, drive)
        put(1'h0, 10'h3f0, 7'h08, 1'h1);
        `CHK("auto_clear", 5'h10, drive)
        put(1'h1, 10'h0f0, 7'h08, 1'h0);
        `CHK("fire_opens", 5'h12, drive)
        vent_switch_close <= 1'h1;
        put(1'h0, 10'h0f0, 7'h08, 1'h1);
        `CHK("switch_stop", 5'h00, drive)
        rd(`VAR_OFF_STATE, `VAR_RESP_OKAY);
        `CHK("state", 32'h3c00, rd_data)
        report_and_stop();
    end
endmodule // var_relay_top_tb
